// ==== logic/btsz_exec.sv ====
module btsz_exec (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Instruction cycle enable and fetched word
    input wire logic cyc_en,
    input wire logic [11:0] fetch_word,
    // File register read port
    output logic [4:0] file_addr,
    input wire logic [7:0] file_data,
    // Executed word and decode status
    output logic [11:0] exec_word,
    output logic skip_nop,
    output logic is_test_zero
);
    // ****************************************
    // Field decode helpers
    // ****************************************
    // True when a word carries the skip-if-zero opcode
    function automatic logic is_skip_zero(
        input logic [11:0] w
    );
        return w[btsz_pkg::OPC_HI:btsz_pkg::OPC_LO] == btsz_pkg::OPC_SKIP_ZERO;
    endfunction : is_skip_zero

    // Index of the tested bit
    function automatic logic [2:0] bit_field(
        input logic [11:0] w
    );
        return w[btsz_pkg::BIT_HI:btsz_pkg::BIT_LO];
    endfunction : bit_field

    // Number of the addressed file register
    function automatic logic [4:0] reg_field(
        input logic [11:0] w
    );
        return w[btsz_pkg::FA_HI:btsz_pkg::FA_LO];
    endfunction : reg_field

    // One bit of a register read
    function automatic logic pick_bit(
        input logic [7:0] d,
        input logic [2:0] i
    );
        return d[i];
    endfunction : pick_bit

    // ****************************************
    // State of the word now executing
    // ****************************************
    logic [11:0] exec_r;
    logic [11:0] exec_nxt;
    logic skip_r;
    logic skip_nxt;
    logic [4:0] faddr_r;
    logic [4:0] faddr_nxt;
    logic tz_r;
    logic tz_nxt;

    // ****************************************
    // Decode of the word now executing, and the register field of the fetched word
    // ****************************************
    wire logic op_match = is_skip_zero(exec_r);
    wire logic [2:0] bit_idx = bit_field(exec_r);
    // A discarded slot never tests, even if its word was a test
    wire logic test_zero = op_match && !skip_r;
    wire logic bit_val = pick_bit(file_data, bit_idx);
    wire logic do_skip = test_zero && !bit_val;
    wire logic [4:0] fetch_reg = reg_field(fetch_word);

    // ****************************************
    // Next-state selection
    // ****************************************
    // No-op in place of the prefetched word on a skip
    assign exec_nxt = cyc_en ? (do_skip ? btsz_pkg::NOP_WORD : fetch_word) : exec_r;
    // The no-op slot is the second cycle of the test
    assign skip_nxt = cyc_en ? do_skip : skip_r;
    // Read only: no write port, so flags and registers stay as they are
    assign faddr_nxt = cyc_en ? fetch_reg : faddr_r;
    assign tz_nxt = is_skip_zero(exec_nxt) && !skip_nxt;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exec_r <= btsz_pkg::RESET_WORD;
        end else begin
            exec_r <= exec_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            skip_r <= btsz_pkg::FLAG_RESET;
        end else begin
            skip_r <= skip_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faddr_r <= btsz_pkg::FADDR_RESET;
        end else begin
            faddr_r <= faddr_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tz_r <= btsz_pkg::FLAG_RESET;
        end else begin
            tz_r <= tz_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign file_addr = faddr_r;
    assign exec_word = exec_r;
    assign skip_nop = skip_r;
    assign is_test_zero = tz_r;

    // ****************************************
    // Checks
    // ****************************************
    a_skip_gives_nop: assert property (
        @(posedge ref_clk) disable iff (rst)
        cyc_en && test_zero && !pick_bit(file_data, bit_idx)
        |=> exec_r == btsz_pkg::NOP_WORD && skip_r
    ) else $error("zero bit did not insert a no-op");

    a_one_bit_runs: assert property (
        @(posedge ref_clk) disable iff (rst)
        cyc_en && test_zero && pick_bit(file_data, bit_idx)
        |=> exec_r == $past(fetch_word) && !skip_r
    ) else $error("one bit did not run next word");

    a_nop_one_slot: assert property (
        @(posedge ref_clk) disable iff (rst)
        cyc_en && skip_r
        |=> !skip_r
    ) else $error("skip lasted more than one slot");

    a_decode_match: assert property (
        @(posedge ref_clk) disable iff (rst)
        is_test_zero == (is_skip_zero(exec_r) && !skip_r)
    ) else $error("decode flag mismatch");

    a_other_no_skip: assert property (
        @(posedge ref_clk) disable iff (rst)
        cyc_en && !is_skip_zero(exec_r)
        |=> !skip_r
    ) else $error("skip without bit test");

    a_hold_no_en: assert property (
        @(posedge ref_clk) disable iff (rst)
        !cyc_en
        |=> $stable(exec_r) && $stable(skip_r)
    ) else $error("state moved without cycle enable");

    a_addr_follows: assert property (
        @(posedge ref_clk) disable iff (rst)
        cyc_en
        |=> file_addr == $past(reg_field(fetch_word))
    ) else $error("file address not from fetched word");

    a_skip_cause: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(skip_r)
        |-> $past(test_zero) && !$past(bit_val)
    ) else $error("skip without zero bit");

    a_slot_no_test: assert property (
        @(posedge ref_clk) disable iff (rst)
        skip_nop
        |-> !is_test_zero && exec_word == btsz_pkg::NOP_WORD
    ) else $error("inserted slot seen as a live test");

    a_two_cycle_end: assert property (
        @(posedge ref_clk) disable iff (rst)
        cyc_en && test_zero && !bit_val ##1 cyc_en
        |=> !skip_r && exec_r == $past(fetch_word)
    ) else $error("skipped test took more than two cycles");

    a_non_test_passes: assert property (
        @(posedge ref_clk) disable iff (rst)
        cyc_en && !test_zero
        |=> exec_r == $past(fetch_word) && !skip_r
    ) else $error("non-test slot altered the next word");

    a_hold_addr: assert property (
        @(posedge ref_clk) disable iff (rst)
        !cyc_en
        |=> $stable(file_addr) && $stable(is_test_zero)
    ) else $error("address or flag moved without cycle enable");
endmodule : btsz_exec

// ==== shared/btsz_pkg.sv ====
package btsz_pkg;
    // ****************************************
    // Instruction word layout
    // ****************************************
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 8;
    localparam int BIT_HI = 7;
    localparam int BIT_LO = 5;
    localparam int FA_HI = 4;
    localparam int FA_LO = 0;
    localparam logic [3:0] OPC_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OPC_SKIP_ONE = 4'h7;
    // No-operation word issued in place of a discarded instruction
    localparam logic [11:0] NOP_WORD = 12'h000;
    localparam logic [11:0] RESET_WORD = 12'h000;
    // Reset values of the address and status registers
    localparam logic [4:0] FADDR_RESET = 5'h00;
    localparam logic FLAG_RESET = 1'b0;
endpackage : btsz_pkg

// ==== verif/bit_test_skip_clear_exec_tb.sv ====
module bit_test_skip_clear_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc_en = 1'b0;
    logic [11:0] fetch_word = 12'h000;
    logic [11:0] exec_word;
    logic [7:0] file_data, d;
    logic [4:0] file_addr;
    logic skip_nop, is_test_zero, s;
    int miscompares = 0;
    int checks = 0;
    always #25 ref_clk = ~ref_clk;
    btsz_exec i_btsz_exec (.ref_clk(ref_clk), .rst(rst), .cyc_en(cyc_en),
        .fetch_word(fetch_word), .file_addr(file_addr), .file_data(file_data),
        .exec_word(exec_word), .skip_nop(skip_nop), .is_test_zero(is_test_zero));
    btsz_file_model i_btsz_file_model (.file_addr(file_addr), .file_data(file_data));
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task issue(input logic [11:0] w);
        @(posedge ref_clk);
        fetch_word <= w;
        cyc_en <= 1'b1;
        #1;
    endtask : issue
    task seq(input logic [11:0] t, input logic [11:0] w);
        d = {t[4:0], t[2:0]};
        s = (t[11:8] == 4'h6) && !d[t[7:5]];
        issue(t);
        issue(w);
        chk(is_test_zero, t[11:8] == 4'h6);
        chk(file_addr, t[4:0]);
        issue(12'h0a5);
        chk(exec_word, s ? btsz_pkg::NOP_WORD : w);
        chk(skip_nop, s);
        issue(12'h000);
        chk(exec_word, 12'h0a5);
        chk(skip_nop, 1'b0);
    endtask : seq
    task give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk(exec_word, btsz_pkg::RESET_WORD);
        for (int b = 0; b < 8; b++) seq({4'h6, b[2:0], 5'h15}, 12'h0c3);
        // Discarded word is itself a test: the slot must not skip
        seq(12'h600, 12'h600);
        seq(12'h6ff, 12'h0c3);
        seq(12'h2e0, 12'h0c3);
        give_verdict();
    end
endmodule : bit_test_skip_clear_exec_tb

// ==== verif/btsz_file_model.sv ====
module btsz_file_model (
    // File register read port
    input wire logic [4:0] file_addr,
    output logic [7:0] file_data
);
    timeunit 1ns;
    timeprecision 1ns;
    assign file_data = {file_addr, file_addr[2:0]};
endmodule : btsz_file_model
